// ### fsr_bank.sv
// Status register bank of a serial NOR flash.
// Assumes a command decoder that presents one opcode pulse per command,
// with address and data already assembled, and an array engine that
// reports completion and failure.
module fsr_bank
    import fsr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        cmd_valid,
    input  wire logic [7:0]  cmd_code,
    input  wire logic [24:0] cmd_addr,
    input  wire logic [7:0]  cmd_data,
    input  wire logic        cmd_byte_ok,
    input  wire logic        otp_target,
    input  wire logic [1:0]  otp_index,
    input  wire logic        op_done,
    input  wire logic        op_failed,
    input  wire logic        mode_bits_repeat,
    input  wire logic        read_start,
    output logic             op_start_prog,
    output logic             op_start_wipe,
    output logic             op_start_array_wipe,
    output logic             op_suspend,
    output logic             op_resume,
    output logic             continuous_read,
    output logic [7:0]       status_reg_low,
    output logic [7:0]       status_reg_mid,
    output logic [7:0]       status_reg_high,
    output logic             busy_flag,
    output logic             write_latch,
    output logic             quad_io_on,
    output logic             ecc_on,
    output logic             addr_width_state,
    output logic [3:0]       dummy_cycles,
    output logic [1:0]       output_strength,
    output logic [2:0]       otp_lock
);
    fsr_op_t     op_q;
    fsr_op_t     op_d;
    logic        paused_q;
    logic        latch_q;
    logic        latch_d;
    logic [3:0]  bp_q;
    logic        bottom_q;
    logic [2:0]  lock_q;
    logic        ecc_q;
    logic        epause_q;
    logic        ppause_q;
    logic [1:0]  dummy_q;
    logic        pfault_q;
    logic        wfault_q;
    logic        boot_aw_q;
    logic [1:0]  drv_q;
    logic        aw_q;
    logic        init_q;
    logic        cont_q;
    logic [7:0]  sr_data_q;
    logic [1:0]  sr_sel_q;

    logic        soft_reset;
    logic        in_region;
    logic        lock_hit;
    logic        is_prog;
    logic        is_wipe;
    logic        is_array;
    logic        is_srwr;
    logic        idle;
    logic        accept_gate;
    logic        ecc_misalign;
    logic        prog_go;
    logic        prog_bad;
    logic        wipe_go;
    logic        wipe_bad;
    logic        array_go;
    logic        srwr_go;
    logic        srwr_commit;
    logic        susp_go;
    logic        resume_go;
    logic        clr_go;

    fsr_reset_seq u_reset_seq
    (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .cmd_valid  (cmd_valid),
        .cmd_code   (cmd_code),
        .soft_reset (soft_reset)
    );

    fsr_protect u_protect
    (
        .block_protect       (bp_q),
        .protect_from_bottom (bottom_q),
        .addr                (cmd_addr),
        .in_region           (in_region)
    );

    // Command classification
    assign is_prog  = cmd_valid && (cmd_code == CMD_PAGE_WRITE || cmd_code == CMD_QUAD_WRITE);
    assign is_wipe  = cmd_valid && (cmd_code == CMD_SECTOR_WIPE || cmd_code == CMD_BLOCK_WIPE);
    assign is_array = cmd_valid && (cmd_code == CMD_ARRAY_WIPE);
    assign is_srwr  = cmd_valid && (cmd_code == CMD_SR_WRITE_LO || cmd_code == CMD_SR_WRITE_MID
                                    || cmd_code == CMD_SR_WRITE_HI);
    assign idle     = (op_q == OP_IDLE);
    // Partial final byte means nothing happens and the latch holds
    assign accept_gate = idle && latch_q && cmd_byte_ok;
    assign lock_hit    = otp_target && lock_q[otp_index];
    assign ecc_misalign = ecc_q && ((cmd_addr[2:0] & ECC_ALIGN_MASK) != 3'h0);

    assign prog_bad = is_prog && accept_gate && (in_region || lock_hit || ecc_misalign);
    assign prog_go  = is_prog && accept_gate && !prog_bad;
    assign wipe_bad = is_wipe && accept_gate && (in_region || lock_hit);
    assign wipe_go  = is_wipe && accept_gate && !wipe_bad;
    assign array_go = is_array && accept_gate && (bp_q == 4'h0);
    assign srwr_go  = is_srwr && accept_gate;
    assign susp_go  = cmd_valid && (cmd_code == CMD_SUSPEND) && !idle && op_q != OP_SRWR;
    assign resume_go = cmd_valid && (cmd_code == CMD_RESUME) && paused_q;
    assign clr_go   = cmd_valid && (cmd_code == CMD_CLR_FLAGS);
    // Status write takes effect on its completion, keeping busy visible meanwhile
    assign srwr_commit = (op_q == OP_SRWR) && op_done;

    always_comb
    begin
        op_d = op_q;
        if (soft_reset)
            op_d = OP_IDLE;
        else if (prog_go)
            op_d = OP_PROG;
        else if (wipe_go || array_go)
            op_d = OP_WIPE;
        else if (srwr_go)
            op_d = OP_SRWR;
        else if (op_done && !paused_q)
            op_d = OP_IDLE;
    end

    always_comb
    begin
        latch_d = latch_q;
        if (cmd_valid && cmd_code == CMD_WRITE_ARM)
            latch_d = 1'b1;
        if ((cmd_valid && cmd_code == CMD_WRITE_DIS) || soft_reset)
            latch_d = 1'b0;
        if (op_done && !idle && !paused_q)
            latch_d = 1'b0;
        if (prog_bad || wipe_bad)
            latch_d = 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            op_q     <= OP_IDLE;
            paused_q <= 1'b0;
            latch_q  <= 1'b0;
            epause_q <= 1'b0;
            ppause_q <= 1'b0;
            pfault_q <= 1'b0;
            wfault_q <= 1'b0;
            cont_q   <= 1'b0;
        end
        else
        begin
            op_q    <= op_d;
            latch_q <= latch_d;
            if (soft_reset || resume_go)
            begin
                paused_q <= 1'b0;
                epause_q <= 1'b0;
                ppause_q <= 1'b0;
            end
            else if (susp_go)
            begin
                paused_q <= 1'b1;
                epause_q <= epause_q || (op_q == OP_WIPE);
                ppause_q <= ppause_q || (op_q == OP_PROG);
            end
            // Hardware set wins over the clear command
            pfault_q <= (prog_bad || (op_q == OP_PROG && op_done && op_failed))
                        || (pfault_q && !clr_go);
            wfault_q <= (wipe_bad || (op_q == OP_WIPE && op_done && op_failed))
                        || (wfault_q && !clr_go);
            // Repeat flag lives only between reads
            if (soft_reset)
                cont_q <= 1'b0;
            else if (read_start)
                cont_q <= mode_bits_repeat;
        end
    end

    // Non-volatile fields: reset models the factory state
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            bp_q      <= RST_BP;
            bottom_q  <= RST_BOTTOM;
            lock_q    <= RST_LOCK;
            ecc_q     <= RST_ECC;
            dummy_q   <= RST_DUMMY;
            boot_aw_q <= RST_BOOT_AW;
            drv_q     <= RST_DRV;
            sr_data_q <= 8'h00;
            sr_sel_q  <= 2'h0;
        end
        else
        begin
            if (srwr_go)
            begin
                sr_data_q <= cmd_data;
                sr_sel_q  <= (cmd_code == CMD_SR_WRITE_LO) ? 2'h0 :
                             (cmd_code == CMD_SR_WRITE_MID) ? 2'h1 : 2'h2;
            end
            if (srwr_commit && sr_sel_q == 2'h0)
            begin
                bp_q     <= sr_data_q[POS_BP_LO +: 4];
                bottom_q <= sr_data_q[POS_BOTTOM];
            end
            if (srwr_commit && sr_sel_q == 2'h1)
            begin
                lock_q <= lock_q | sr_data_q[POS_LOCK_LO +: 3];
                ecc_q  <= sr_data_q[POS_ECC];
            end
            if (srwr_commit && sr_sel_q == 2'h2)
            begin
                dummy_q   <= sr_data_q[POS_DUMMY_LO +: 2];
                boot_aw_q <= sr_data_q[POS_BOOT_AW];
                drv_q     <= sr_data_q[POS_DRV_LO +: 2];
            end
        end
    end

    // Address mode: boot value sampled one edge after reset release
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            init_q <= 1'b1;
            aw_q   <= 1'b0;
        end
        else
        begin
            init_q <= 1'b0;
            if (init_q || soft_reset)
                aw_q <= boot_aw_q;
            else if (cmd_valid && cmd_code == CMD_ENTER_4B)
                aw_q <= 1'b1;
            else if (cmd_valid && cmd_code == CMD_EXIT_4B)
                aw_q <= 1'b0;
        end
    end

    // Register images; busy and fixed bits are not writable
    assign status_reg_low  = {1'b0, bottom_q, bp_q, latch_q, busy_flag};
    assign status_reg_mid  = {epause_q, ecc_q, lock_q, ppause_q, QUAD_FIXED, aw_q};
    assign status_reg_high = {1'b0, drv_q, boot_aw_q, wfault_q, pfault_q, dummy_q};

    assign busy_flag        = !idle && !paused_q;
    assign write_latch      = latch_q;
    assign quad_io_on       = QUAD_FIXED;
    assign ecc_on           = ecc_q;
    assign addr_width_state = aw_q;
    assign dummy_cycles     = dummy_q[1] ? DUMMY_SHORT : DUMMY_LONG;
    assign output_strength  = drv_q;
    assign otp_lock         = lock_q;
    assign continuous_read  = cont_q;
    assign op_start_prog       = prog_go;
    assign op_start_wipe       = wipe_go;
    assign op_start_array_wipe = array_go;
    assign op_suspend          = susp_go;
    assign op_resume           = resume_go;
endmodule : fsr_bank

// ### fsr_pkg.sv
// Shared constants for the flash status register bank.
// Assumes a single clock domain and a command decoder outside this bank.
// How it works
// - busy_flag high while program, erase, write run
// - write_latch low refuses status write, program, erase
// - protect_from_bottom defaults 0 means top region
// - block_protect bits size region; reject writes inside
// - whole array wipe only with block_protect zero
// - quad_io_on always reads one, ignores writes
// - otp_lock bits set once, never clear again
// - ECC on needs aligned eight byte programs
// - suspend sets erase_paused or program_paused flag
// - resume, soft reset, power cycle clear paused flags
// - dummy code 00/01 gives 8, 10/11 gives 6
// - dummy_cycle_code resets to 00
// - continuous read mode skips opcode next access
// - output_strength 00 full, 01 default three quarter
// - program fault on failure, protection or lock
// - wipe fault on failure, protection or lock
// - clear flag command resets both fault flags
// - addr_width_state reports 0 three byte, 1 four
// - boot_addr_width sampled at reset init and at soft reset
// - write latch set by arm, cleared by listed events
package fsr_pkg;
    // Command codes as seen on the serial link
    localparam logic [7:0] CMD_WRITE_ARM    = 8'h06;
    localparam logic [7:0] CMD_WRITE_DIS    = 8'h04;
    localparam logic [7:0] CMD_SR_WRITE_LO  = 8'h01;
    localparam logic [7:0] CMD_SR_WRITE_MID = 8'h31;
    localparam logic [7:0] CMD_SR_WRITE_HI  = 8'h11;
    localparam logic [7:0] CMD_PAGE_WRITE   = 8'h02;
    localparam logic [7:0] CMD_QUAD_WRITE   = 8'h32;
    localparam logic [7:0] CMD_SECTOR_WIPE  = 8'h20;
    localparam logic [7:0] CMD_BLOCK_WIPE   = 8'hD8;
    localparam logic [7:0] CMD_ARRAY_WIPE   = 8'hC7;
    localparam logic [7:0] CMD_SUSPEND      = 8'h75;
    localparam logic [7:0] CMD_RESUME       = 8'h7A;
    localparam logic [7:0] CMD_RST_ARM      = 8'h66;
    localparam logic [7:0] CMD_RST_GO       = 8'h99;
    localparam logic [7:0] CMD_CLR_FLAGS    = 8'h30;
    localparam logic [7:0] CMD_ENTER_4B     = 8'hB7;
    localparam logic [7:0] CMD_EXIT_4B      = 8'hE9;
    // Low register bit positions
    localparam int POS_BUSY   = 0;
    localparam int POS_LATCH  = 1;
    localparam int POS_BP_LO  = 2;
    localparam int POS_BOTTOM = 6;
    // Mid register bit positions (within byte)
    localparam int POS_ADDR_ST = 0;
    localparam int POS_QUAD    = 1;
    localparam int POS_PPAUSE  = 2;
    localparam int POS_LOCK_LO = 3;
    localparam int POS_ECC     = 6;
    localparam int POS_EPAUSE  = 7;
    // High register bit positions (within byte)
    localparam int POS_DUMMY_LO = 0;
    localparam int POS_PFAULT   = 2;
    localparam int POS_WFAULT   = 3;
    localparam int POS_BOOT_AW  = 4;
    localparam int POS_DRV_LO   = 5;
    // Reset values
    localparam logic [3:0] RST_BP       = 4'h0;
    localparam logic       RST_BOTTOM   = 1'b0;
    localparam logic [2:0] RST_LOCK     = 3'h0;
    localparam logic       RST_ECC      = 1'b0;
    localparam logic [1:0] RST_DUMMY    = 2'h0;
    localparam logic       RST_BOOT_AW  = 1'b0;
    localparam logic [1:0] RST_DRV      = 2'h1;
    localparam logic       QUAD_FIXED   = 1'b1;
    // Dummy clocks per latency code group
    localparam logic [3:0] DUMMY_LONG   = 4'h8;
    localparam logic [3:0] DUMMY_SHORT  = 4'h6;
    // Array geometry: 64KB blocks, 512 of them
    localparam int BLK_SHIFT = 16;
    localparam int BLK_BITS  = 9;
    localparam logic [2:0] ECC_ALIGN_MASK = 3'h7;

    typedef enum logic [1:0]
    {
        OP_IDLE  = 2'b00,
        OP_PROG  = 2'b01,
        OP_WIPE  = 2'b10,
        OP_SRWR  = 2'b11
    } fsr_op_t;
endpackage : fsr_pkg

// ### fsr_protect.sv
// Protected region check for block_protect and protect_from_bottom.
// Assumes a 25-bit byte address into 512 blocks of 64KB.
module fsr_protect
    import fsr_pkg::*;
(
    input  wire logic [3:0]  block_protect,
    input  wire logic        protect_from_bottom,
    input  wire logic [24:0] addr,
    output logic             in_region
);
    logic [BLK_BITS-1:0] blk;
    logic [BLK_BITS:0]   count;
    logic                all_prot;

    assign blk = addr[BLK_SHIFT +: BLK_BITS];
    // Codes 1..9 cover 2^(n-1) blocks; 1010 and above cover all
    assign all_prot = (block_protect[3] && block_protect[2] && !block_protect[1])
                    || (block_protect[3] && block_protect[1])
                    || (block_protect[3] && !block_protect[2] && block_protect[1]);
    assign count = (block_protect == 4'h0) ? 10'h000 :
                   (block_protect > 4'h9) ? 10'h200 :
                   10'(10'h001 << (block_protect - 4'h1));
    assign in_region = (block_protect == 4'h0) ? 1'b0 :
                       all_prot ? 1'b1 :
                       protect_from_bottom ? ({1'b0, blk} < count)
                                           : ({1'b0, blk} >= 10'(10'h200 - count));
endmodule : fsr_protect

// ### fsr_reset_seq.sv
// Two-command software reset detector.
// Assumes cmd_valid pulses once per decoded opcode.
module fsr_reset_seq
    import fsr_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       cmd_valid,
    input  wire logic [7:0] cmd_code,
    output logic            soft_reset
);
    logic armed_q;
    logic armed_d;

    // Any other command between the pair disarms it
    assign armed_d    = cmd_valid ? (cmd_code == CMD_RST_ARM) : armed_q;
    assign soft_reset = cmd_valid && armed_q && (cmd_code == CMD_RST_GO);

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            armed_q <= 1'b0;
        else
            armed_q <= armed_d;
    end
endmodule : fsr_reset_seq

// ### fsr_bank_asserts.sv
// Concurrent checks on the ports of the status register bank.
// Assumes one clock domain; bound to fsr_bank from the testbench file.
module fsr_bank_asserts
    import fsr_pkg::*;
(
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic       cmd_byte_ok,
    input wire logic       op_done,
    input wire logic       mode_bits_repeat,
    input wire logic       read_start,
    input wire logic       op_start_prog,
    input wire logic       op_start_array_wipe,
    input wire logic       continuous_read,
    input wire logic [7:0] status_reg_low,
    input wire logic [7:0] status_reg_mid,
    input wire logic [7:0] status_reg_high,
    input wire logic       busy_flag,
    input wire logic       write_latch,
    input wire logic       quad_io_on,
    input wire logic [3:0] dummy_cycles,
    input wire logic [2:0] otp_lock
);
    timeunit 1ns;
    timeprecision 1ns;
    logic is_srwr;
    assign is_srwr = cmd_code inside {CMD_SR_WRITE_LO, CMD_SR_WRITE_MID, CMD_SR_WRITE_HI};
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    sequence s_srwr_take;
        cmd_valid && is_srwr && write_latch && !busy_flag && cmd_byte_ok
            && !status_reg_mid[POS_PPAUSE] && !status_reg_mid[POS_EPAUSE];
    endsequence
    sequence s_op_end;
        op_done && busy_flag;
    endsequence
    a_quad_fixed: assert property (quad_io_on && status_reg_mid[POS_QUAD])
        else $error("quad enable not held at one");
    a_reserved_zero: assert property (!status_reg_low[7] && !status_reg_high[7])
        else $error("reserved bit reads one");
    a_dummy_map: assert property (dummy_cycles == (status_reg_high[1] ? DUMMY_SHORT : DUMMY_LONG))
        else $error("dummy count does not follow code");
    a_arm_sets: assert property (cmd_valid && cmd_code == CMD_WRITE_ARM && !busy_flag |=> write_latch)
        else $error("write arm did not set latch");
    a_latch_refuse: assert property (cmd_valid && !write_latch |-> !op_start_prog && !op_start_array_wipe)
        else $error("operation started without latch");
    a_array_guard: assert property (op_start_array_wipe |-> status_reg_low[5:2] == 4'h0)
        else $error("array wipe started with protection set");
    a_srwr_busy: assert property (s_srwr_take |=> busy_flag)
        else $error("status write did not raise busy");
    a_done_idle: assert property (s_op_end |=> !busy_flag && !write_latch)
        else $error("busy or latch left after completion");
    a_lock_sticky: assert property (($past(otp_lock) & ~otp_lock) == 3'h0)
        else $error("lock bit returned to zero");
    a_clear_faults: assert property (cmd_valid && cmd_code == CMD_CLR_FLAGS && !op_done
        |=> status_reg_high[3:2] == 2'h0)
        else $error("fault flags not cleared");
    a_cont_read: assert property (read_start |=> continuous_read == $past(mode_bits_repeat))
        else $error("continuous read not taken from mode bits");
endmodule : fsr_bank_asserts

// ### fsr_engine.sv
// Behavioural array engine that answers the bank's operations.
// Assumes busy_flag marks a running operation; counts hold while paused.
module fsr_engine
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       busy_flag,
    input  wire logic       op_resume,
    input  wire logic       fail_next,
    input  wire logic [7:0] op_len,
    output logic            op_done,
    output logic            op_failed
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cnt_q;
    logic       busy_prev_q;
    logic       resumed_q;
    logic       fresh;
    logic       finish;
    // A resumed operation keeps its count rather than restarting
    assign fresh = busy_flag && !busy_prev_q && !resumed_q;
    assign finish = !sys_rst && busy_flag && !op_done && cnt_q == op_len;
    always_ff @(posedge clk)
    begin
        busy_prev_q <= busy_flag;
        resumed_q <= op_resume;
        if (sys_rst || fresh)
            cnt_q <= 8'h01;
        else if (busy_flag)
            cnt_q <= cnt_q + 8'h01;
        op_done <= finish;
        op_failed <= finish && fail_next;
    end
endmodule : fsr_engine

// ### fsr_bank_tb.sv
// Self-checking testbench for the status register bank.
// Assumes fsr_engine as array engine and the checker bound below.
module fsr_bank_tb
    import fsr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, sys_rst, cmd_valid, cmd_byte_ok, otp_target, fail_next;
    logic        mode_bits_repeat, read_start, op_done, op_failed, op_start_prog;
    logic        op_start_wipe, op_start_array_wipe, op_suspend, op_resume;
    logic        continuous_read, busy_flag, write_latch, quad_io_on, ecc_on, addr_width_state;
    logic [7:0]  cmd_code, cmd_data, op_len, status_reg_low, status_reg_mid, status_reg_high;
    logic [24:0] cmd_addr;
    logic [3:0]  dummy_cycles;
    logic [1:0]  output_strength, otp_index;
    logic [2:0]  otp_lock;
    logic [4:0]  starts;
    int          err_count, checked, i;
    fsr_bank dut_u (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_byte_ok(cmd_byte_ok),
        .otp_target(otp_target), .otp_index(otp_index), .op_done(op_done), .op_failed(op_failed),
        .mode_bits_repeat(mode_bits_repeat), .read_start(read_start),
        .op_start_prog(op_start_prog), .op_start_wipe(op_start_wipe),
        .op_start_array_wipe(op_start_array_wipe), .op_suspend(op_suspend),
        .op_resume(op_resume), .continuous_read(continuous_read),
        .status_reg_low(status_reg_low), .status_reg_mid(status_reg_mid),
        .status_reg_high(status_reg_high), .busy_flag(busy_flag), .write_latch(write_latch),
        .quad_io_on(quad_io_on), .ecc_on(ecc_on), .addr_width_state(addr_width_state),
        .dummy_cycles(dummy_cycles), .output_strength(output_strength), .otp_lock(otp_lock));
    fsr_engine eng_u (.clk(clk), .sys_rst(sys_rst), .busy_flag(busy_flag),
        .op_resume(op_resume), .fail_next(fail_next), .op_len(op_len), .op_done(op_done),
        .op_failed(op_failed));
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask : tick
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp)
        begin
            $display("ERROR %s expected %h seen %h", nm, exp, got);
            err_count++;
        end
    endtask : chk
    task automatic cmd(input logic [7:0] c, input logic [24:0] a, input logic [7:0] d);
        cmd_code = c;
        cmd_addr = a;
        cmd_data = d;
        cmd_valid = 1'b1;
        #1 starts = {op_start_prog, op_start_wipe, op_start_array_wipe, op_suspend, op_resume};
        tick(1);
        cmd_valid = 1'b0;
        tick(1);
    endtask : cmd
    task automatic wr(input logic [7:0] c, input logic [24:0] a, input logic [7:0] d);
        cmd(CMD_WRITE_ARM, 25'h0, 8'h00);
        cmd(c, a, d);
    endtask : wr
    task automatic idle();
        int n;
        n = 0;
        while (busy_flag !== 1'b0 && n < 300)
        begin
            tick(1);
            n++;
        end
        chk("busy_flag", 8'h00, busy_flag);
        tick(1);
    endtask : idle
    task automatic regs(input logic [7:0] lo, input logic [7:0] mi, input logic [7:0] hi);
        chk("status_reg_low", lo, status_reg_low);
        chk("status_reg_mid", mi, status_reg_mid);
        chk("status_reg_high", hi, status_reg_high);
    endtask : regs
    task automatic prog_try(input logic [24:0] a, input logic f);
        wr(CMD_PAGE_WRITE, a, 8'h00);
        idle();
        chk("program_fault_flag", f, status_reg_high[POS_PFAULT]);
        cmd(CMD_CLR_FLAGS, 25'h0, 8'h00);
    endtask : prog_try
    task automatic rd(input logic m);
        mode_bits_repeat = m;
        read_start = 1'b1;
        tick(1);
        read_start = 1'b0;
        tick(1);
        chk("continuous_read", m, continuous_read);
    endtask : rd
    task automatic do_reset();
        sys_rst = 1'b1;
        tick(6);
        sys_rst = 1'b0;
        tick(2);
        regs(8'h00, 8'h02, 8'h20);
    endtask : do_reset
    task automatic conclude();
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    // Tests need about 300 cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        conclude();
    end
    initial
    begin
        {sys_rst, cmd_valid, otp_target, fail_next, mode_bits_repeat, read_start} = 6'h20;
        {otp_index, cmd_code, cmd_data, cmd_addr} = 43'h0;
        cmd_byte_ok = 1'b1;
        op_len = 8'h04;
        err_count = 0;
        checked = 0;
        #10;
        do_reset();
        cmd(CMD_SR_WRITE_LO, 25'h0, 8'h3C);
        idle();
        regs(8'h00, 8'h02, 8'h20);
        cmd(CMD_WRITE_ARM, 25'h0, 8'h00);
        cmd_byte_ok = 1'b0;
        cmd(CMD_SR_WRITE_LO, 25'h0, 8'h3C);
        cmd_byte_ok = 1'b1;
        chk("status_reg_low", 8'h02, status_reg_low);
        cmd(CMD_WRITE_DIS, 25'h0, 8'h00);
        chk("write_latch", 8'h00, write_latch);
        wr(CMD_SR_WRITE_LO, 25'h0, 8'hFF);
        idle();
        chk("status_reg_low", 8'h7C, status_reg_low);
        prog_try(25'h0000000, 1'b1);
        wr(CMD_ARRAY_WIPE, 25'h0, 8'h00);
        chk("busy_flag", 8'h00, busy_flag);
        for (i = 0; i < 2; i++)
        begin
            wr(i == 0 ? CMD_SECTOR_WIPE : CMD_BLOCK_WIPE, 25'h1000000, 8'h00);
            idle();
            chk("wipe_fault_flag", 8'h01, status_reg_high[POS_WFAULT]);
            cmd(CMD_CLR_FLAGS, 25'h0, 8'h00);
            chk("status_reg_high", 8'h20, status_reg_high);
        end
        wr(CMD_SR_WRITE_LO, 25'h0, 8'h00);
        idle();
        wr(CMD_ARRAY_WIPE, 25'h0, 8'h00);
        chk("op_start", 8'h04, starts);
        chk("busy_flag", 8'h01, busy_flag);
        idle();
        chk("status_reg_low", 8'h00, status_reg_low);
        wr(CMD_SR_WRITE_LO, 25'h0, 8'h44);
        idle();
        prog_try(25'h000FFFF, 1'b1);
        prog_try(25'h0010000, 1'b0);
        wr(CMD_SR_WRITE_LO, 25'h0, 8'h04);
        idle();
        prog_try(25'h1FF0000, 1'b1);
        prog_try(25'h1FEFFF8, 1'b0);
        wr(CMD_SR_WRITE_LO, 25'h0, 8'h00);
        idle();
        wr(CMD_SR_WRITE_MID, 25'h0, 8'hFF);
        idle();
        chk("status_reg_mid", 8'h7A, status_reg_mid);
        chk("ecc_otp", 8'h0F, {ecc_on, otp_lock});
        prog_try(25'h0000003, 1'b1);
        prog_try(25'h0000008, 1'b0);
        {otp_target, otp_index} = 3'h6;
        prog_try(25'h0000000, 1'b1);
        otp_target = 1'b0;
        wr(CMD_SR_WRITE_MID, 25'h0, 8'h00);
        idle();
        chk("status_reg_mid", 8'h3A, status_reg_mid);
        fail_next = 1'b1;
        prog_try(25'h0000000, 1'b1);
        fail_next = 1'b0;
        op_len = 8'h1E;
        wr(CMD_QUAD_WRITE, 25'h0, 8'h00);
        chk("op_start", 8'h10, starts);
        cmd(CMD_SUSPEND, 25'h0, 8'h00);
        chk("op_start", 8'h02, starts);
        chk("status_reg_mid", 8'h3E, status_reg_mid);
        cmd(CMD_RESUME, 25'h0, 8'h00);
        chk("op_start", 8'h01, starts);
        chk("status_reg_mid", 8'h3A, status_reg_mid);
        chk("busy_flag", 8'h01, busy_flag);
        idle();
        wr(CMD_SECTOR_WIPE, 25'h0, 8'h00);
        cmd(CMD_SUSPEND, 25'h0, 8'h00);
        chk("status_reg_mid", 8'hBA, status_reg_mid);
        cmd(CMD_RST_ARM, 25'h0, 8'h00);
        cmd(CMD_RST_GO, 25'h0, 8'h00);
        regs(8'h00, 8'h3A, 8'h20);
        op_len = 8'h04;
        for (i = 0; i < 4; i++)
        begin
            wr(CMD_SR_WRITE_HI, 25'h0, 8'h10 | i[7:0]);
            idle();
            chk("status_reg_high", 8'h10 | i[7:0], status_reg_high);
            chk("dummy_cycles", i > 1 ? DUMMY_SHORT : DUMMY_LONG, dummy_cycles);
        end
        chk("output_strength", 8'h00, output_strength);
        cmd(CMD_RST_ARM, 25'h0, 8'h00);
        cmd(CMD_RST_GO, 25'h0, 8'h00);
        tick(1);
        chk("addr_width_state", 8'h01, addr_width_state);
        cmd(CMD_EXIT_4B, 25'h0, 8'h00);
        chk("addr_width_state", 8'h00, addr_width_state);
        cmd(CMD_ENTER_4B, 25'h0, 8'h00);
        chk("addr_width_state", 8'h01, addr_width_state);
        rd(1'b1);
        rd(1'b0);
        do_reset();
        conclude();
    end
endmodule : fsr_bank_tb
bind fsr_bank fsr_bank_asserts chk_u (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_byte_ok(cmd_byte_ok), .op_done(op_done),
    .mode_bits_repeat(mode_bits_repeat), .read_start(read_start),
    .op_start_prog(op_start_prog), .op_start_array_wipe(op_start_array_wipe),
    .continuous_read(continuous_read), .status_reg_low(status_reg_low),
    .status_reg_mid(status_reg_mid), .status_reg_high(status_reg_high),
    .busy_flag(busy_flag), .write_latch(write_latch), .quad_io_on(quad_io_on),
    .dummy_cycles(dummy_cycles), .otp_lock(otp_lock));
